//--- core/asi_receive_slot_mapper.sv
`timescale 1ns/1ps
module asi_receive_slot_mapper #(
    parameter int unsigned WORD_W = 32
) (
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    input  wire asi_rx_pkg::apb_req_t    apb_req_i,
    output asi_rx_pkg::apb_rsp_t         apb_rsp_o,
    input  wire logic                    bit_clock_i,
    input  wire logic                    frame_sync_i,
    input  wire logic                    primary_data_input_i,
    input  wire logic                    secondary_data_input_i,
    input  wire logic                    controller_mode_i,
    input  wire logic                    int_bit_clock_i,
    input  wire logic                    int_frame_sync_i,
    input  wire logic                    bit_clock_polarity_setting_i,
    input  wire asi_rx_pkg::asi_format_t format_i,
    output logic [7:0]                   rx_pin_choice_o,
    output logic [31:0]                  dac_ch1_data_o,
    output logic                         dac_ch1_valid_o
);
    import asi_rx_pkg::*;

    typedef struct packed {
        rx_timing_config_t timing;
        logic [REG_W-1:0]  pin_select;
        rx_channel1_map_t  ch1;
        logic              bclk_prev;
        logic              fs_prev;
        logic              active;
        logic [5:0]        skip;
        logic [4:0]        bitc;
        logic [SLOT_W-1:0] slotc;
        logic [DATA_W-1:0] shift;
        logic [DATA_W-1:0] dac_data;
        logic              dac_valid;
        apb_rsp_t          rsp;
    } state_t;

    state_t            r, next_r;
    logic [3:0]        sync_q;
    logic              bclk_sel, fs_sel, pin_bit, edge_fall, strobe;
    logic              fs_rise, fs_fall, half_start, right_half, is_tdm, is_i2s;
    logic [5:0]        skip_now;
    logic [4:0]        bit_now;
    logic [SLOT_W-1:0] slot_now;
    logic              skipping, match, capture, last_bit, counting;
    logic              setup, access, mapped;
    logic [REG_W-1:0]  rd_byte;

    pin_sync #(.WIDTH(4)) u_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    ({bit_clock_i, frame_sync_i, primary_data_input_i, secondary_data_input_i}),
        .q_o    (sync_q)
    );

    // Internal sources skip the synchroniser; they share this clock already.
    assign bclk_sel   = (controller_mode_i && r.timing.rx_latch_internal_bit_clock)
                        ? int_bit_clock_i : sync_q[3];
    assign fs_sel     = (controller_mode_i && r.timing.rx_latch_internal_frame_sync)
                        ? int_frame_sync_i : sync_q[2];
    assign pin_bit    = r.pin_select[0] ? sync_q[0] : sync_q[1];
    assign edge_fall  = bit_clock_polarity_setting_i ^ r.timing.rx_sample_edge_invert;
    assign strobe     = (bclk_sel != r.bclk_prev) && (bclk_sel == !edge_fall);
    assign is_tdm     = (format_i == FMT_TDM);
    assign is_i2s     = (format_i == FMT_I2S);
    assign fs_rise    = strobe && fs_sel && !r.fs_prev;
    assign fs_fall    = strobe && !fs_sel && r.fs_prev;
    assign half_start = fs_rise || (!is_tdm && fs_fall);
    assign right_half = is_i2s ? fs_sel : !fs_sel;
    // The same delay is applied to both data inputs since they share one bit counter.
    assign skip_now   = half_start ? (6'(r.timing.rx_msb_bit_delay) + (is_i2s ? I2S_LEAD_BIT : 6'h00))
                                   : r.skip;
    assign bit_now    = half_start ? 5'h00 : r.bitc;
    assign slot_now   = half_start ? '0 : r.slotc;
    assign skipping   = (skip_now != 6'h00);
    assign counting   = strobe && (r.active || half_start);
    assign last_bit   = (bit_now == 5'(WORD_W - 1));
    assign match      = is_tdm ? (slot_now == {1'b0, r.ch1.rx_chan1_slot_index})
                               : ((slot_now < HALF_SLOTS) && (slot_now[3:0] == r.ch1.rx_chan1_slot_index[3:0])
                                  && (right_half == r.ch1.rx_chan1_slot_index[4]));
    assign capture    = counting && !skipping && match && r.ch1.rx_chan1_enable;

    assign setup  = apb_req_i.psel && !apb_req_i.penable;
    assign access = apb_req_i.psel && apb_req_i.penable && r.rsp.pready;
    assign mapped = (apb_req_i.paddr == ADDR_RX_TIMING_CONFIG) || (apb_req_i.paddr == ADDR_RX_PIN_SELECT)
                    || (apb_req_i.paddr == ADDR_RX_CHANNEL1_MAP);

    always_comb begin
        unique case (apb_req_i.paddr)
            ADDR_RX_TIMING_CONFIG: rd_byte = r.timing;
            ADDR_RX_PIN_SELECT:    rd_byte = r.pin_select;
            ADDR_RX_CHANNEL1_MAP:  rd_byte = {2'h0, r.ch1[5:0]};
            default:               rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_r             = r;
        next_r.bclk_prev   = bclk_sel;
        next_r.dac_valid   = 1'b0;
        next_r.rsp.pready  = setup;
        next_r.rsp.pslverr = setup && !mapped;
        next_r.rsp.prdata  = (setup && !apb_req_i.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        if (access && apb_req_i.pwrite && mapped && apb_req_i.pstrb[0]) begin
            unique case (apb_req_i.paddr)
                ADDR_RX_TIMING_CONFIG: next_r.timing     = apb_req_i.pwdata[REG_W-1:0];
                ADDR_RX_PIN_SELECT:    next_r.pin_select = apb_req_i.pwdata[REG_W-1:0];
                // Reserved bits are dropped on write so they always read back as zero.
                default:               next_r.ch1        = {2'h0, apb_req_i.pwdata[5:0]};
            endcase
        end
        if (strobe) begin
            next_r.fs_prev = fs_sel;
        end
        if (half_start) begin
            next_r.active = 1'b1;
        end
        if (counting) begin
            next_r.bitc  = bit_now;
            next_r.slotc = slot_now;
            if (skipping) begin
                next_r.skip = skip_now - 6'h01;
            end else begin
                next_r.skip = 6'h00;
                if (last_bit) begin
                    next_r.bitc  = 5'h00;
                    next_r.slotc = (slot_now == SLOT_MAX) ? slot_now : slot_now + 6'h01;
                end else begin
                    next_r.bitc = bit_now + 5'h01;
                end
            end
        end
        if (capture) begin
            next_r.shift = (bit_now == 5'h00) ? {31'h0, pin_bit} : {r.shift[DATA_W-2:0], pin_bit};
            if (last_bit) begin
                next_r.dac_data  = next_r.shift;
                next_r.dac_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r            <= '0;
            r.timing     <= RST_RX_TIMING_CONFIG;
            r.pin_select <= RST_RX_PIN_SELECT;
            r.ch1        <= RST_RX_CHANNEL1_MAP;
        end else begin
            r <= next_r;
        end
    end

    assign apb_rsp_o       = r.rsp;
    assign rx_pin_choice_o = r.pin_select;
    assign dac_ch1_data_o  = r.dac_data;
    assign dac_ch1_valid_o = r.dac_valid;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_edge_select;
        strobe |-> (bclk_sel == !(bit_clock_polarity_setting_i ^ r.timing.rx_sample_edge_invert))
                   && (r.bclk_prev != bclk_sel);
    endproperty
    a_edge_select: assert property (p_edge_select) else $error("Sample taken on wrong clock edge.");

    property p_int_fsync;
        (controller_mode_i && r.timing.rx_latch_internal_frame_sync && int_frame_sync_i && strobe)
            |=> r.fs_prev;
    endproperty
    a_int_fsync: assert property (p_int_fsync) else $error("Internal frame sync not followed.");

    property p_ext_bclk;
        !(controller_mode_i && r.timing.rx_latch_internal_bit_clock) |=> r.bclk_prev == $past(sync_q[3]);
    endproperty
    a_ext_bclk: assert property (p_ext_bclk) else $error("External bit clock not followed.");

    property p_offset;
        half_start |=> r.skip == ($past(is_i2s) ? 6'($past(r.timing.rx_msb_bit_delay))
                                  : ($past(r.timing.rx_msb_bit_delay) == 5'h00 ? 6'h00
                                     : 6'($past(r.timing.rx_msb_bit_delay)) - 6'h01));
    endproperty
    a_offset: assert property (p_offset) else $error("MSB delay count wrong.");

    property p_pin_capture;
        capture && (bit_now == 5'h00)
            |=> r.shift[0] == ($past(r.pin_select[0]) ? $past(sync_q[0]) : $past(sync_q[1]));
    endproperty
    a_pin_capture: assert property (p_pin_capture) else $error("Bit taken from wrong pin.");

    property p_disabled;
        !r.ch1.rx_chan1_enable |=> !dac_ch1_valid_o;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Disabled channel produced data.");

    property p_ch1_reset;
        $past(srst_i) |-> (r.ch1 == RST_RX_CHANNEL1_MAP) && (r.timing == RST_RX_TIMING_CONFIG);
    endproperty
    a_ch1_reset: assert property (p_ch1_reset) else $error("Reset values wrong.");

    property p_slot_match;
        $rose(dac_ch1_valid_o) |-> $past(match) && $past(last_bit) && !$past(skipping);
    endproperty
    a_slot_match: assert property (p_slot_match) else $error("Word from unselected slot.");

    property p_reserved;
        r.ch1.reserved == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("Reserved bits became nonzero.");

    property p_valid_pulse;
        dac_ch1_valid_o |=> !dac_ch1_valid_o [*2];
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("Word strobe longer than one cycle.");

    property p_apb_answer;
        setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("Bus answer timing wrong.");

    c_tdm_word: cover property (is_tdm && dac_ch1_valid_o);
    c_i2s_right: cover property (is_i2s && dac_ch1_valid_o && r.ch1.rx_chan1_slot_index[4]);
    c_offset_word: cover property ((r.timing.rx_msb_bit_delay != 5'h00) && dac_ch1_valid_o);
    c_secondary_pin: cover property (r.pin_select[0] && dac_ch1_valid_o);
endmodule // asi_receive_slot_mapper

//--- common/asi_rx_pkg.sv
package asi_rx_pkg;

    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned REG_W  = 8;

    // Register offsets are word indices; the byte address is four times the index.
    localparam logic [7:0]        IDX_RX_TIMING_CONFIG  = 8'h26;
    localparam logic [7:0]        IDX_RX_PIN_SELECT     = 8'h27;
    localparam logic [7:0]        IDX_RX_CHANNEL1_MAP   = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_RX_TIMING_CONFIG = {IDX_RX_TIMING_CONFIG, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RX_PIN_SELECT    = {IDX_RX_PIN_SELECT, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RX_CHANNEL1_MAP  = {IDX_RX_CHANNEL1_MAP, 2'h0};

    localparam logic [REG_W-1:0] RST_RX_TIMING_CONFIG = 8'h00;
    localparam logic [REG_W-1:0] RST_RX_PIN_SELECT    = 8'h00;
    localparam logic [REG_W-1:0] RST_RX_CHANNEL1_MAP  = 8'h20;

    localparam int unsigned SLOT_W       = 6;
    localparam logic [5:0]  SLOT_MAX     = 6'h3f;
    localparam logic [5:0]  HALF_SLOTS   = 6'h10;
    localparam logic [5:0]  I2S_LEAD_BIT = 6'h01;

    typedef enum logic [1:0] {
        FMT_TDM,
        FMT_I2S,
        FMT_LJ
    } asi_format_t;

    typedef struct packed {
        logic       rx_sample_edge_invert;
        logic       rx_latch_internal_frame_sync;
        logic       rx_latch_internal_bit_clock;
        logic [4:0] rx_msb_bit_delay;
    } rx_timing_config_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic       rx_chan1_enable;
        logic [4:0] rx_chan1_slot_index;
    } rx_channel1_map_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } apb_rsp_t;

endpackage

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t r, next_r;

    // The first stage feeds only the second one, so metastability never reaches logic.
    always_comb begin
        next_r.meta   = d_i;
        next_r.stable = r.meta;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.stable;
endmodule // pin_sync

//--- sim/asi_host_model.sv
`timescale 1ns/1ps
module asi_host_model #(
    parameter int unsigned W = 8
) (
    output logic       bclk_o,
    output logic       fs_o,
    output logic [1:0] din_o
);
    import asi_rx_pkg::*;

    initial begin
        bclk_o = 1'b0;
        fs_o   = 1'b0;
        din_o  = 2'b00;
    end

    function automatic logic [W-1:0] word_of(input int s, input int pin);
        return W'(s * 37 + pin * 91 + 12);
    endfunction

    // The clock stands still between frames; idle data pins show the inverse of their last bit.
    // A late launch moves data just after the rising edge, so only a falling-edge sampler sees it right.
    task automatic send(input asi_format_t fmt, input int dly, input logic late);
        int half, nb, h, idx, s;
        logic fsv;
        logic [1:0] b;
        logic [W-1:0] w0, w1;
        half = (fmt == FMT_TDM) ? 32 * W + dly : 16 * W + dly + 1;
        nb   = (fmt == FMT_TDM) ? half : 2 * half;
        for (int k = -2; k < nb; k++) begin
            h   = (fmt != FMT_TDM && k >= half) ? 1 : 0;
            idx = k - h * half - dly - ((fmt == FMT_I2S) ? 1 : 0);
            s   = idx / W + 16 * h;
            fsv = (fmt == FMT_TDM) ? (k == 0) : ((k >= 0 && h == 0) ^ (fmt == FMT_I2S));
            b   = ~din_o;
            if (k >= 0 && idx >= 0 && idx / W < ((fmt == FMT_TDM) ? 32 : 16)) begin
                w0   = word_of(s, 0);
                w1   = word_of(s, 1);
                b[0] = w0[W - 1 - idx % W];
                b[1] = w1[W - 1 - idx % W];
            end
            if (!late) begin
                din_o = b;
                fs_o  = fsv;
                #31.25 bclk_o = 1'b1;
                #62.5 bclk_o = 1'b0;
                #31.25;
            end else begin
                bclk_o = 1'b1;
                #31.25 din_o = b;
                fs_o = fsv;
                #31.25 bclk_o = 1'b0;
                #62.5;
            end
        end
    endtask
endmodule // asi_host_model

//--- sim/asi_receive_slot_mapper_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
module asi_receive_slot_mapper_tb;
    import asi_rx_pkg::*;

    typedef struct packed {
        asi_format_t fmt;
        logic [4:0]  dly;
        logic [4:0]  slot;
        logic        pin, inv, pol, late;
        logic [1:0]  bits, rt;
        logic        ctrl, en, exp;
    } row_t;

    logic        clk_i, srst_i, ctrl, pol, hb, hf, valid, er;
    logic [1:0]  hd, rt;
    logic [7:0]  pins;
    logic [31:0] dac, rd;
    asi_format_t fmt;
    apb_req_t    req;
    apb_rsp_t    rsp;
    row_t        r;
    int          fail_count, checked, vcount;
    logic [7:0]  rstv [3] = '{RST_RX_TIMING_CONFIG, RST_RX_PIN_SELECT, RST_RX_CHANNEL1_MAP};
    row_t        rows [12] = '{
        '{FMT_TDM, 5'd0, 5'd0, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd31, 5'd31, 1'b1, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd5, 5'd17, 1'b1, 1'b1, 1'b0, 1'b1, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd0, 5'd3, 1'b0, 1'b0, 1'b1, 1'b1, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd2, 5'd9, 1'b1, 1'b1, 1'b1, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_LJ, 5'd2, 5'd15, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_LJ, 5'd0, 5'd16, 1'b1, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_I2S, 5'd1, 5'd31, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd0, 5'd2, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 2'b11, 1'b1, 1'b1, 1'b1},
        '{FMT_TDM, 5'd3, 5'd4, 1'b1, 1'b0, 1'b0, 1'b0, 2'b10, 2'b01, 1'b1, 1'b1, 1'b1},
        '{FMT_TDM, 5'd0, 5'd6, 1'b0, 1'b0, 1'b0, 1'b0, 2'b11, 2'b00, 1'b0, 1'b1, 1'b1},
        '{FMT_TDM, 5'd0, 5'd1, 1'b0, 1'b0, 1'b0, 1'b0, 2'b00, 2'b00, 1'b0, 1'b0, 1'b0}};

    asi_host_model #(.W(8)) u_host (.bclk_o(hb), .fs_o(hf), .din_o(hd));

    // Routing sends the host clock and sync either to the pins or to the internal inputs.
    asi_receive_slot_mapper #(.WORD_W(8)) u_dut (
        .clk_i(clk_i), .srst_i(srst_i), .apb_req_i(req), .apb_rsp_o(rsp),
        .bit_clock_i(hb & ~rt[1]), .frame_sync_i(hf & ~rt[0]),
        .primary_data_input_i(hd[0]), .secondary_data_input_i(hd[1]), .controller_mode_i(ctrl),
        .int_bit_clock_i(hb & rt[1]), .int_frame_sync_i(hf & rt[0]), .bit_clock_polarity_setting_i(pol),
        .format_i(fmt), .rx_pin_choice_o(pins), .dac_ch1_data_o(dac), .dac_ch1_valid_o(valid));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) if (valid === 1'b1) vcount++;

    task apb(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= a;
        req.pwdata  <= wd;
        req.pstrb   <= 4'hf;
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task wrap_up;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #800000;
        fail_count++;
        wrap_up();
    end

    initial begin
        srst_i = 1'b1;
        req = '0;
        {ctrl, pol, rt} = 4'h0;
        fmt = FMT_TDM;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            @(posedge clk_i);
            ctrl <= r.ctrl;
            pol  <= r.pol;
            fmt  <= r.fmt;
            rt   <= r.rt;
            apb(1'b1, ADDR_RX_TIMING_CONFIG, {24'h0, r.inv, r.bits, r.dly});
            apb(1'b1, ADDR_RX_PIN_SELECT, {24'h0, 7'(i), r.pin});
            apb(1'b1, ADDR_RX_CHANNEL1_MAP, {24'h0, 2'b00, r.en, r.slot});
            `CHK(pins, {7'(i), r.pin})
            vcount = 0;
            u_host.send(r.fmt, r.dly, r.late);
            repeat (10) @(posedge clk_i);
            `CHK(vcount, int'(r.exp))
            if (r.exp) `CHK(dac, {24'h0, u_host.word_of(r.slot, r.pin)})
        end
        // A second reset in mid-run must bring back every reset value.
        srst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        srst_i <= 1'b0;
        `CHK(pins, 8'h00)
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, ADDR_RX_TIMING_CONFIG + 10'(4 * k), 32'h0);
            `CHK({er, rd}, {1'b0, 24'h0, rstv[k]})
        end
        apb(1'b1, ADDR_RX_CHANNEL1_MAP, 32'h0000_00ff);
        apb(1'b0, ADDR_RX_CHANNEL1_MAP, 32'h0);
        `CHK(rd, 32'h0000_003f)
        apb(1'b0, 10'h000, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0})
        wrap_up();
    end
endmodule // asi_receive_slot_mapper_tb
